// *** sim/conv_feed.sv ***
`timescale 1ns/10ps
`default_nettype none
module conv_feed (
    output logic conv_clk_o = 1'h0,
    output logic light_done_o = 1'h0,
    output logic near_done_o = 1'h0,
    output logic [11:0] light_data_o = 12'h5A5,
    output wire logic [7:0] near_data_o
);
    assign near_data_o = light_data_o[7:0];
    // One result a frame; clock still and data inverted between frames
    task automatic send(input logic near, input logic [11:0] v, input int k);
        repeat (k) begin
            light_done_o = !near;
            near_done_o = near;
            light_data_o = v;
            #40 conv_clk_o = 1'h1;
            #40 conv_clk_o = 1'h0;
            #40 light_done_o = 1'h0;
            near_done_o = 1'h0;
            light_data_o = ~v;
            #40;
        end
    endtask
endmodule
`default_nettype wire

// *** sim/light_prox_irq_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module light_prox_irq_bench;
    logic mclk_i = 1'h0, rst_n_i = 1'h0;
    logic wait_r, int_n, oe, pdn, rng, cclk, ldone, ndone;
    logic [1:0] rq = 2'h0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [11:0] ana, ldat;
    logic [7:0] ndat;
    logic [6:0] i2c;
    logic win, len, nen, vis, led;
    logic [2:0] slp;
    int bad_count = 0, n_compared = 0;
    always #2.5 mclk_i = ~mclk_i;
    light_prox_irq #(.WINDOW_CYCLES(64)) light_prox_irq_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .avs_address_i(addr),
        .avs_read_i(rq[0]), .avs_write_i(rq[1]), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
        .conv_clk_i(cclk), .light_done_i(ldone), .near_done_i(ndone), .light_data_i(ldat),
        .near_data_i(ndat), .int_n_o(int_n), .analog_light_current_out_o(ana),
        .analog_light_oe_o(oe), .light_enable_o(len), .near_enable_o(nen),
        .light_window_o(win), .light_range_select_o(rng),
        .visible_or_infrared_select_o(vis), .power_down_o(pdn),
        .led_sink_driver_strength_o(led), .near_sleep_interval_o(slp), .i2c_address_o(i2c));
    conv_feed conv_feed_inst (.conv_clk_o(cclk), .light_done_o(ldone),
        .near_done_o(ndone), .light_data_o(ldat), .near_data_o(ndat));
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge mclk_i);
        rq <= w ? 2'h2 : 2'h1;
        addr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge mclk_i);
            n++;
        end while (wait_r !== 1'h0 && n < 40);
        if (wait_r !== 1'h0) begin
            bad_count++;
            $display("[FAIL] %0t bus answer timed out", $time);
            end_of_test;
        end
        if (!w) chk(rdat, {24'h0, d});
        rq <= 2'h0;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic t_light;
        chk(pdn, 1'h1);
        chk(i2c, 7'h44);
        acc(1'h0, 6'h1C, 8'hFF);
        acc(1'h1, 6'h04, 8'h04);
        chk(pdn, 1'h0);
        acc(1'h1, 6'h1C, 8'h10);
        conv_feed_inst.send(1'h0, 12'h2A5, 1);
        chk(int_n, 1'h0);
        chk(ana, 12'h2A5);
        acc(1'h0, 6'h24, 8'hA5);
        conv_feed_inst.send(1'h0, 12'h100, 1);
        acc(1'h0, 6'h08, 8'h08);
        acc(1'h1, 6'h08, 8'h09);
        chk(int_n, 1'h1);
        acc(1'h1, 6'h08, 8'h00);
        acc(1'h0, 6'h08, 8'h00);
        $display("light test done");
    endtask
    task automatic t_near;
        acc(1'h1, 6'h0C, 8'h20);
        acc(1'h1, 6'h10, 8'h80);
        acc(1'h1, 6'h08, 8'h20);
        acc(1'h1, 6'h04, 8'h80);
        chk(oe, 1'h0);
        conv_feed_inst.send(1'h1, 12'h090, 3);
        conv_feed_inst.send(1'h1, 12'h010, 1);
        conv_feed_inst.send(1'h1, 12'h090, 3);
        acc(1'h0, 6'h08, 8'h20);
        conv_feed_inst.send(1'h1, 12'h090, 1);
        acc(1'h0, 6'h08, 8'hA0);
        chk(int_n, 1'h0);
        conv_feed_inst.send(1'h1, 12'h010, 4);
        acc(1'h0, 6'h08, 8'h20);
        acc(1'h0, 6'h20, 8'h10);
        chk(int_n, 1'h1);
        acc(1'h1, 6'h04, 8'h72);
        chk(pdn, 1'h1);
        chk(rng, 1'h1);
        chk({nen, slp, led, len, rng, vis}, 8'h72);
        $display("near test done");
    endtask
    task automatic t_host;
        int n = 0;
        acc(1'h1, 6'h04, 8'h00);
        acc(1'h1, 6'h3C, 8'h29);
        acc(1'h1, 6'h38, 8'h00);
        acc(1'h1, 6'h3C, 8'h00);
        acc(1'h0, 6'h3C, 8'h00);
        chk(pdn, 1'h1);
        // Settle time scaled down for simulation
        repeat (200) @(negedge mclk_i);
        acc(1'h1, 6'h1C, 8'hFF);
        acc(1'h1, 6'h14, 8'h80);
        acc(1'h1, 6'h04, 8'h04);
        conv_feed_inst.send(1'h0, 12'h7D0, 1);
        chk(int_n, 1'h1);
        acc(1'h0, 6'h28, 8'h07);
        acc(1'h0, 6'h24, 8'hD0);
        if (!rng && ana > 12'h708) acc(1'h1, 6'h04, 8'h06);
        chk(rng, 1'h1);
        repeat (128) @(negedge mclk_i) n += win;
        chk(n, 32'h2);
        conv_feed_inst.send(1'h0, 12'h07D, 1);
        chk(ana, 12'h07D);
        chk(int_n, 1'h0);
        $display("host test done");
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        t_light;
        t_near;
        t_host;
        end_of_test;
    end
endmodule
`default_nettype wire

// *** verilog/light_prox_irq.sv ***
// What this block does
// R01: Light flag sets when result leaves window.
// R02: Light flag holds until software writes zero.
// R03: Near flag sets after high-threshold run.
// R04: Near flag clears on low run or write.
// R05: Independent persistence counts gate each flag.
// R06: Combine bit selects AND or OR.
// R07: Analog output follows light result when enabled.
// R08: Host switches to high range above 1800.
// R09: Host writes recovery sequence after power glitch.
// R10: Host waits about 1 ms, rewrites registers.
// R11: Both enables zero means power-down.
// R12: Range select bit 1 of config.
// R13: Light result once per 100 ms window.
// R14: Fixed seven-bit serial slave address.
// R15: Light result split across two bytes.
// R16: Light thresholds packed, reset zero and ones.
// R17: Near result is read-only 8-bit register.
// R18: Sleep interval field bits 6 to 4.
// R19: Interrupt pin releases when combination false.
// R20: Persistence runs restart on any miss.
`timescale 1ns/10ps
`default_nettype none
module light_prox_irq
    import light_prox_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = light_prox_pkg::LIGHT_WINDOW_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [light_prox_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [light_prox_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [light_prox_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic conv_clk_i,
    input wire logic light_done_i,
    input wire logic near_done_i,
    input wire logic [light_prox_pkg::LIGHT_W-1:0] light_data_i,
    input wire logic [light_prox_pkg::NEAR_W-1:0] near_data_i,
    output logic int_n_o,
    output logic [light_prox_pkg::LIGHT_W-1:0] analog_light_current_out_o,
    output logic analog_light_oe_o,
    output logic light_enable_o,
    output logic near_enable_o,
    output logic light_range_select_o,
    output logic visible_or_infrared_select_o,
    output logic led_sink_driver_strength_o,
    output logic [2:0] near_sleep_interval_o,
    output logic power_down_o,
    output logic light_window_o,
    output logic [6:0] i2c_address_o
);
    localparam int SYNC_W = 3 + LIGHT_W + NEAR_W;
    localparam int WIN_W = $clog2(WINDOW_CYCLES);

    if (WINDOW_CYCLES < 2) begin : g_bad_window
        $error("WINDOW_CYCLES must be at least 2");
    end

    // Converter side crossing
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_stable;
    logic conv_clk_prev;
    logic conv_edge;
    logic light_sample;
    logic near_sample;
    logic [LIGHT_W-1:0] light_s_data;
    logic [NEAR_W-1:0] near_s_data;

    // Register file
    bus_state_t bus_state;
    bus_state_t next_bus_state;
    logic next_waitrequest;
    logic [DATA_W-1:0] next_readdata;
    logic [7:0] config_reg;
    logic [7:0] next_config_reg;
    logic [7:0] irq_ctrl;
    logic [7:0] next_irq_ctrl;
    logic [7:0] near_low_threshold;
    logic [7:0] next_near_low_threshold;
    logic [7:0] near_high_threshold;
    logic [7:0] next_near_high_threshold;
    logic [LIGHT_W-1:0] light_low_threshold;
    logic [LIGHT_W-1:0] next_light_low_threshold;
    logic [LIGHT_W-1:0] light_high_threshold;
    logic [LIGHT_W-1:0] next_light_high_threshold;
    logic [7:0] test1;
    logic [7:0] next_test1;
    logic [7:0] test2;
    logic [7:0] next_test2;
    logic [LIGHT_W-1:0] light_result;
    logic [LIGHT_W-1:0] next_light_result;
    logic [NEAR_W-1:0] near_result;
    logic [NEAR_W-1:0] next_near_result;
    logic light_irq_flag;
    logic next_light_irq_flag;
    logic near_irq_flag;
    logic next_near_irq_flag;
    logic [3:0] reg_index;
    logic addr_ok;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic irq_write;

    // Persistence and outputs
    logic light_outside;
    logic light_fire;
    logic near_set_fire;
    logic near_clr_fire;
    logic irq_active;
    logic next_int_n;
    logic [LIGHT_W-1:0] next_analog;
    logic next_analog_oe;
    logic next_power_down;
    logic [WIN_W-1:0] window_count;
    logic [WIN_W-1:0] next_window_count;
    logic next_light_window;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_meta <= '0;
            sync_stable <= '0;
            conv_clk_prev <= 1'b0;
        end else if (ce_i) begin
            sync_meta <= {conv_clk_i, light_done_i, near_done_i, light_data_i, near_data_i};
            sync_stable <= sync_meta;
            conv_clk_prev <= sync_stable[SYNC_W-1];
        end
    end

    assign light_s_data = sync_stable[NEAR_W +: LIGHT_W];
    assign near_s_data = sync_stable[0 +: NEAR_W];
    assign conv_edge = sync_stable[SYNC_W-1] & ~conv_clk_prev;
    // Disabled channels take no samples in power-down
    assign light_sample = conv_edge & sync_stable[SYNC_W-2] & config_reg[CFG_LIGHT_EN_BIT]; // [R11]
    assign near_sample = conv_edge & sync_stable[SYNC_W-3] & config_reg[CFG_NEAR_EN_BIT]; // [R11]

    // Window compare on the incoming result
    assign light_outside = (light_s_data < light_low_threshold)
        || (light_s_data > light_high_threshold); // [R01]

    persist_filter #(.CNT_W(PERSIST_W)) u_light_persist (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .sample_i(light_sample),
        .hit_i(light_outside),
        .target_i(persist_target(irq_ctrl[IRQ_LIGHT_PRST_LSB +: 2])), // [R05]
        .fire_o(light_fire)
    );

    persist_filter #(.CNT_W(PERSIST_W)) u_near_set_persist (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .sample_i(near_sample),
        .hit_i(near_s_data > near_high_threshold), // [R03]
        .target_i(persist_target(irq_ctrl[IRQ_NEAR_PRST_LSB +: 2])), // [R05]
        .fire_o(near_set_fire)
    );

    persist_filter #(.CNT_W(PERSIST_W)) u_near_clr_persist (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .sample_i(near_sample),
        .hit_i(near_s_data < near_low_threshold), // [R04]
        .target_i(persist_target(irq_ctrl[IRQ_NEAR_PRST_LSB +: 2])),
        .fire_o(near_clr_fire)
    );

    assign reg_index = avs_address_i[5:2];
    assign addr_ok = (avs_address_i[1:0] == 2'h0);
    assign wd = avs_writedata_i[7:0];
    assign irq_write = (bus_state == BUS_ANSWER) && avs_write_i && avs_byteenable_i[0]
        && addr_ok && (reg_index == REG_IRQ);

    // Register read mux, unmapped reads as zero
    always_comb begin
        rd_byte = 8'h00;
        if (!addr_ok) begin
            rd_byte = 8'h00;
        end else if (reg_index == REG_CONFIG) begin
            rd_byte = config_reg;
        end else if (reg_index == REG_IRQ) begin
            rd_byte = irq_ctrl;
            rd_byte[IRQ_NEAR_FLAG_BIT] = near_irq_flag;
            rd_byte[IRQ_LIGHT_FLAG_BIT] = light_irq_flag;
        end else if (reg_index == REG_NEAR_LOW) begin
            rd_byte = near_low_threshold;
        end else if (reg_index == REG_NEAR_HIGH) begin
            rd_byte = near_high_threshold;
        end else if (reg_index == REG_LIGHT_TH1) begin
            rd_byte = light_low_threshold[7:0]; // [R16]
        end else if (reg_index == REG_LIGHT_TH2) begin
            rd_byte = {light_high_threshold[3:0], light_low_threshold[11:8]}; // [R16]
        end else if (reg_index == REG_LIGHT_TH3) begin
            rd_byte = light_high_threshold[11:4]; // [R16]
        end else if (reg_index == REG_NEAR_RESULT) begin
            rd_byte = near_result; // [R17]
        end else if (reg_index == REG_LIGHT_LO) begin
            rd_byte = light_result[7:0]; // [R15]
        end else if (reg_index == REG_LIGHT_HI) begin
            rd_byte = {4'h0, light_result[11:8]}; // [R15]
        end else if (reg_index == REG_TEST1) begin
            rd_byte = test1;
        end else if (reg_index == REG_TEST2) begin
            rd_byte = test2;
        end
    end

    // Bus handshake, register writes, flags and results
    always_comb begin
        next_bus_state = bus_state;
        next_waitrequest = avs_waitrequest_o;
        next_readdata = avs_readdata_o;
        next_config_reg = config_reg;
        next_irq_ctrl = irq_ctrl;
        next_near_low_threshold = near_low_threshold;
        next_near_high_threshold = near_high_threshold;
        next_light_low_threshold = light_low_threshold;
        next_light_high_threshold = light_high_threshold;
        next_test1 = test1;
        next_test2 = test2;
        next_light_irq_flag = light_irq_flag;
        next_near_irq_flag = near_irq_flag;
        next_light_result = light_result;
        next_near_result = near_result;
        case (bus_state)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    next_bus_state = BUS_ANSWER;
                    next_waitrequest = 1'b0;
                    next_readdata = {{(DATA_W-8){1'b0}}, rd_byte};
                end
            end
            BUS_ANSWER: begin
                next_bus_state = BUS_IDLE;
                next_waitrequest = 1'b1;
                if (avs_write_i && avs_byteenable_i[0] && addr_ok) begin
                    if (reg_index == REG_CONFIG) begin
                        next_config_reg = wd; // [R11] [R12] [R18]
                    end else if (reg_index == REG_IRQ) begin
                        next_irq_ctrl = wd & IRQ_STORE_MASK; // [R06]
                        if (!wd[IRQ_LIGHT_FLAG_BIT]) begin
                            next_light_irq_flag = 1'b0; // [R02]
                        end
                        if (!wd[IRQ_NEAR_FLAG_BIT]) begin
                            next_near_irq_flag = 1'b0; // [R04]
                        end
                    end else if (reg_index == REG_NEAR_LOW) begin
                        next_near_low_threshold = wd;
                    end else if (reg_index == REG_NEAR_HIGH) begin
                        next_near_high_threshold = wd;
                    end else if (reg_index == REG_LIGHT_TH1) begin
                        next_light_low_threshold[7:0] = wd; // [R16]
                    end else if (reg_index == REG_LIGHT_TH2) begin
                        next_light_high_threshold[3:0] = wd[7:4]; // [R16]
                        next_light_low_threshold[11:8] = wd[3:0];
                    end else if (reg_index == REG_LIGHT_TH3) begin
                        next_light_high_threshold[11:4] = wd; // [R16]
                    end else if (reg_index == REG_TEST1) begin
                        next_test1 = wd;
                    end else if (reg_index == REG_TEST2) begin
                        next_test2 = wd;
                    end
                end
            end
            default: begin
                next_bus_state = BUS_IDLE;
                next_waitrequest = 1'b1;
            end
        endcase
        // Hardware events win over a same-cycle clear
        if (near_clr_fire) begin
            next_near_irq_flag = 1'b0; // [R04]
        end
        if (near_set_fire) begin
            next_near_irq_flag = 1'b1; // [R03]
        end
        if (light_fire) begin
            next_light_irq_flag = 1'b1; // [R01]
        end
        if (light_sample) begin
            next_light_result = light_s_data; // [R15]
        end
        if (near_sample) begin
            next_near_result = near_s_data; // [R17]
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= '0;
            config_reg <= CONFIG_RESET;
            irq_ctrl <= IRQ_CTRL_RESET;
            near_low_threshold <= NEAR_LOW_RESET;
            near_high_threshold <= NEAR_HIGH_RESET;
            light_low_threshold <= LIGHT_LOW_RESET;
            light_high_threshold <= LIGHT_HIGH_RESET;
            test1 <= TEST_RESET;
            test2 <= TEST_RESET;
            light_irq_flag <= 1'b0;
            near_irq_flag <= 1'b0;
            light_result <= '0;
            near_result <= '0;
        end else if (ce_i) begin
            bus_state <= next_bus_state;
            avs_waitrequest_o <= next_waitrequest;
            avs_readdata_o <= next_readdata;
            config_reg <= next_config_reg;
            irq_ctrl <= next_irq_ctrl;
            near_low_threshold <= next_near_low_threshold;
            near_high_threshold <= next_near_high_threshold;
            light_low_threshold <= next_light_low_threshold;
            light_high_threshold <= next_light_high_threshold;
            test1 <= next_test1;
            test2 <= next_test2;
            light_irq_flag <= next_light_irq_flag;
            near_irq_flag <= next_near_irq_flag;
            light_result <= next_light_result;
            near_result <= next_near_result;
        end
    end

    // Config fields straight out of the config register
    assign light_enable_o = config_reg[CFG_LIGHT_EN_BIT];
    assign near_enable_o = config_reg[CFG_NEAR_EN_BIT];
    assign light_range_select_o = config_reg[CFG_RANGE_BIT]; // [R12]
    assign visible_or_infrared_select_o = config_reg[CFG_VIS_IR_BIT];
    assign led_sink_driver_strength_o = config_reg[CFG_LED_DRIVE_BIT];
    assign near_sleep_interval_o = config_reg[CFG_SLEEP_LSB +: 3]; // [R18]

    // Pin, analog output, power-down and window timer
    always_comb begin
        irq_active = irq_ctrl[IRQ_COMBINE_BIT] ? (light_irq_flag & near_irq_flag)
            : (light_irq_flag | near_irq_flag); // [R06]
        next_int_n = ~irq_active; // [R19]
        next_analog_oe = config_reg[CFG_LIGHT_EN_BIT]; // [R07]
        next_analog = config_reg[CFG_LIGHT_EN_BIT] ? light_result : '0; // [R07]
        next_power_down = ~config_reg[CFG_NEAR_EN_BIT] & ~config_reg[CFG_LIGHT_EN_BIT]; // [R11]
        next_window_count = window_count;
        next_light_window = 1'b0;
        if (!config_reg[CFG_LIGHT_EN_BIT]) begin
            next_window_count = '0;
        end else if (window_count == WIN_W'(WINDOW_CYCLES - 1)) begin
            next_window_count = '0; // [R13]
            next_light_window = 1'b1;
        end else begin
            next_window_count = window_count + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_n_o <= 1'b1;
            analog_light_oe_o <= 1'b0;
            analog_light_current_out_o <= '0;
            power_down_o <= 1'b1;
            window_count <= '0;
            light_window_o <= 1'b0;
            i2c_address_o <= I2C_SLAVE_ADDR; // [R14]
        end else if (ce_i) begin
            int_n_o <= next_int_n;
            analog_light_oe_o <= next_analog_oe;
            analog_light_current_out_o <= next_analog;
            power_down_o <= next_power_down;
            window_count <= next_window_count;
            light_window_o <= next_light_window;
            i2c_address_o <= I2C_SLAVE_ADDR;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);

    a_light_flag_set: assert property (light_fire |=> light_irq_flag) // [R01]
        else $error("light flag missed a window event");
    a_light_flag_hold: assert property (light_irq_flag && !irq_write |=> light_irq_flag) // [R02]
        else $error("light flag cleared without a write");
    a_near_flag_set: assert property (near_set_fire |=> near_irq_flag) // [R03]
        else $error("near flag missed a high run");
    a_near_flag_clear: assert property (near_clr_fire && !near_set_fire |=> !near_irq_flag) // [R04]
        else $error("near flag not cleared by low run");
    a_int_and_mode: assert property ((irq_ctrl[IRQ_COMBINE_BIT] && !near_irq_flag)[*2] // [R06]
        |-> int_n_o)
        else $error("pin asserted in AND mode with one flag");
    a_int_release: assert property ((!light_irq_flag && !near_irq_flag)[*2] |-> int_n_o) // [R19]
        else $error("pin held low with no flag");
    a_analog_hiz: assert property ((!config_reg[CFG_LIGHT_EN_BIT])[*2] // [R07]
        |-> !analog_light_oe_o && analog_light_current_out_o == '0)
        else $error("analog output driven while light disabled");
    a_power_down: assert property ((config_reg == 8'h00)[*2] |-> power_down_o) // [R11]
        else $error("not in power-down with both enables off");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:2] !avs_waitrequest_o)
        else $error("bus request not answered");

    c_light_flag: cover property (!light_irq_flag ##1 light_irq_flag);
    c_near_cycle: cover property (near_irq_flag ##[1:200] !near_irq_flag);
    c_int_low: cover property (!int_n_o);
    c_irq_write: cover property (irq_write);
endmodule
`default_nettype wire

// *** verilog/light_prox_pkg.sv ***
`default_nettype none
package light_prox_pkg;
    // Clock rate and light integration window
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned LIGHT_WINDOW_MS = 100;
    localparam int unsigned LIGHT_WINDOW_CYCLES = LIGHT_WINDOW_MS * CLK_KHZ;

    // Widths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int LIGHT_W = 12;
    localparam int NEAR_W = 8;
    localparam int PERSIST_W = 5;

    // Fixed serial bus slave address
    localparam logic [6:0] I2C_SLAVE_ADDR = 7'h44;

    // Register indices, byte address is four times the index
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_IRQ = 4'h2;
    localparam logic [3:0] REG_NEAR_LOW = 4'h3;
    localparam logic [3:0] REG_NEAR_HIGH = 4'h4;
    localparam logic [3:0] REG_LIGHT_TH1 = 4'h5;
    localparam logic [3:0] REG_LIGHT_TH2 = 4'h6;
    localparam logic [3:0] REG_LIGHT_TH3 = 4'h7;
    localparam logic [3:0] REG_NEAR_RESULT = 4'h8;
    localparam logic [3:0] REG_LIGHT_LO = 4'h9;
    localparam logic [3:0] REG_LIGHT_HI = 4'hA;
    localparam logic [3:0] REG_TEST1 = 4'hE;
    localparam logic [3:0] REG_TEST2 = 4'hF;

    // Config register fields
    localparam int CFG_NEAR_EN_BIT = 7;
    localparam int CFG_SLEEP_LSB = 4;
    localparam int CFG_LED_DRIVE_BIT = 3;
    localparam int CFG_LIGHT_EN_BIT = 2;
    localparam int CFG_RANGE_BIT = 1;
    localparam int CFG_VIS_IR_BIT = 0;

    // Interrupt register fields
    localparam int IRQ_NEAR_FLAG_BIT = 7;
    localparam int IRQ_NEAR_PRST_LSB = 5;
    localparam int IRQ_LIGHT_FLAG_BIT = 3;
    localparam int IRQ_LIGHT_PRST_LSB = 1;
    localparam int IRQ_COMBINE_BIT = 0;
    localparam logic [7:0] IRQ_STORE_MASK = 8'h67;

    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] NEAR_LOW_RESET = 8'h00;
    localparam logic [7:0] NEAR_HIGH_RESET = 8'hFF;
    localparam logic [11:0] LIGHT_LOW_RESET = 12'h000;
    localparam logic [11:0] LIGHT_HIGH_RESET = 12'hFFF;
    localparam logic [7:0] TEST_RESET = 8'h00;

    // Persistence run lengths
    localparam logic [4:0] PERSIST_1 = 5'h01;
    localparam logic [4:0] PERSIST_4 = 5'h04;
    localparam logic [4:0] PERSIST_8 = 5'h08;
    localparam logic [4:0] PERSIST_16 = 5'h10;

    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

    function automatic logic [4:0] persist_target(input logic [1:0] code);
        case (code)
            2'h0: persist_target = PERSIST_1;
            2'h1: persist_target = PERSIST_4;
            2'h2: persist_target = PERSIST_8;
            default: persist_target = PERSIST_16;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** verilog/persist_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module persist_filter #(
    parameter int CNT_W = 5
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic sample_i,
    input wire logic hit_i,
    input wire logic [CNT_W-1:0] target_i,
    output logic fire_o
);
    logic [CNT_W-1:0] run_count;
    logic [CNT_W-1:0] next_run_count;
    logic [CNT_W:0] run_plus;

    if (CNT_W < 5) begin : g_bad_width
        $error("persist_filter needs CNT_W of at least 5");
    end

    always_comb begin
        run_plus = {1'b0, run_count} + 1'b1;
        next_run_count = run_count;
        fire_o = 1'b0;
        if (sample_i) begin
            if (!hit_i) begin
                next_run_count = '0; // [R20]
            end else if (run_plus >= {1'b0, target_i}) begin
                fire_o = 1'b1; // [R05]
                next_run_count = target_i;
            end else begin
                next_run_count = run_plus[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_count <= '0;
        end else if (ce_i) begin
            run_count <= next_run_count;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);

    a_run_broken: assert property (sample_i && !hit_i |=> run_count == '0) // [R20]
        else $error("run count not cleared on a miss");
    a_fire_needs_run: assert property (fire_o |-> sample_i && hit_i // [R05]
        && (run_count != '0 || target_i <= 5'h01))
        else $error("fired before the run was long enough");
endmodule
`default_nettype wire
